// >>> core/ppd_cfg.svh
// Offsets, field positions, reset values and timing counts of the port
// transfer control block.
// Assumes a 4-bit word address on the plain register port.
`ifndef PPD_CFG_SVH
`define PPD_CFG_SVH

`define PPD_ADDR_W          4
`define PPD_OFF_DATA        4'h0
`define PPD_OFF_STATUS      4'h1
`define PPD_OFF_DEVCTL      4'h2
`define PPD_OFF_ADDR_FIFO   4'h3
`define PPD_OFF_DATA_FIFO   4'h4
`define PPD_OFF_COMPAT_FIFO 4'h5
`define PPD_OFF_EXTCTL      4'h6
`define PPD_OFF_FAIRNESS    4'h7
`define PPD_OFF_SETUP       4'h8
`define PPD_OFF_CFG_A       4'h9
`define PPD_OFF_CFG_B       4'ha

`define PPD_RST_FAIRNESS    8'h07
`define PPD_RST_SETUP       8'h00
`define PPD_RST_DEVCTL      8'h00
`define PPD_RST_EXTCTL      8'h00

`define PPD_DEVCTL_STB      0
`define PPD_DEVCTL_AFD      1
`define PPD_DEVCTL_DIR      5
`define PPD_EXT_SERVICE     2
`define PPD_EXT_DMA_EN      3
`define PPD_SETUP_DEMAND    6
`define PPD_SETUP_USER      7
`define PPD_CFGA_USER       3

`define PPD_SYS_CLK_KHZ     250000
`define PPD_LOGIC_CLK_KHZ   24000
`define PPD_TICK_DIV        ((`PPD_SYS_CLK_KHZ + `PPD_LOGIC_CLK_KHZ - 1) / `PPD_LOGIC_CLK_KHZ)
`define PPD_FLUSH_TERM      8'hff
`define PPD_DEMAND_BURST    3'd4
`define PPD_THRESHOLD       5'd4
`define PPD_INACT_BASE      8'd8
`define PPD_INACT_STEP      8'd32
`define PPD_ACT_STEP        6'd4
`define PPD_ACT_MIN         6'd1

`endif

// >>> core/ppd_pkg.sv
// Types shared by the port transfer control block.
// Assumes nothing beyond a SystemVerilog compiler.
package ppd_pkg;
    typedef enum logic [2:0]
    {
        PPD_M_STD    = 3'h0,
        PPD_M_BIDIR  = 3'h1,
        PPD_M_PFIFO  = 3'h2,
        PPD_M_EFIFO  = 3'h3,
        PPD_M_EPP    = 3'h4,
        PPD_M_RSVD   = 3'h5,
        PPD_M_TEST   = 3'h6,
        PPD_M_CONFIG = 3'h7
    } ppd_mode_t;

    typedef enum logic [4:0]
    {
        PPD_FW_IDLE  = 5'h01,
        PPD_FW_SETUP = 5'h02,
        PPD_FW_STB   = 5'h04,
        PPD_FW_WHI   = 5'h08,
        PPD_FW_WLO   = 5'h10
    } ppd_fw_state_t;
endpackage

// >>> core/ppd_top.sv
// Parallel port transfer control: register file, tagged FIFO, DMA request
// with fairness and demand mode, flush time-out, forward writer, backward
// capture with run-length expansion.
// Assumes a plain one-cycle register port on clk and asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
`include "ppd_cfg.svh"

module ppd_top
    import ppd_pkg::*;
#(
    parameter int DEPTH  = 16,
    parameter int CNT_W  = 5
)
(
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic [`PPD_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_we,
    input  wire logic                   reg_re,
    output logic      [7:0]             reg_rdata,
    output logic                        dma_req,
    input  wire logic                   dma_ack_n,
    input  wire logic [7:0]             dma_wdata,
    output logic      [7:0]             dma_rdata,
    input  wire logic [7:0]             port_data_lines_i,
    output logic      [7:0]             port_data_lines_o,
    output logic                        port_data_lines_oe,
    output logic                        strobe_line_n,
    output logic                        autofeed_line_n,
    input  wire logic                   busy_line,
    input  wire logic                   peri_ack_n
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [1:0] ack_s_q;
    logic [1:0] busy_s_q;
    logic [1:0] pack_s_q;
    logic [7:0] dw_s1_q;
    logic [7:0] dw_s2_q;
    logic [7:0] pd_s1_q;
    logic [7:0] pd_s2_q;
    logic       ack_old_q;
    logic       pack_old_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_s_q    <= 2'h3;
            busy_s_q   <= 2'h0;
            pack_s_q   <= 2'h3;
            dw_s1_q    <= 8'h00;
            dw_s2_q    <= 8'h00;
            pd_s1_q    <= 8'h00;
            pd_s2_q    <= 8'h00;
            ack_old_q  <= 1'b1;
            pack_old_q <= 1'b1;
        end
        else
        begin
            ack_s_q    <= {ack_s_q[0], dma_ack_n};
            busy_s_q   <= {busy_s_q[0], busy_line};
            pack_s_q   <= {pack_s_q[0], peri_ack_n};
            dw_s1_q    <= dma_wdata;
            dw_s2_q    <= dw_s1_q;
            pd_s1_q    <= port_data_lines_i;
            pd_s2_q    <= pd_s1_q;
            ack_old_q  <= ack_s_q[1];
            pack_old_q <= pack_s_q[1];
        end
    end

    wire busy     = busy_s_q[1];
    wire dma_xfer = ack_old_q & ~ack_s_q[1];
    wire peri_stb = pack_old_q & ~pack_s_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] data_q;
    logic [7:0] devctl_q;
    logic [7:0] extctl_q;
    logic [7:0] fair_q;
    logic [7:0] setup_q;
    logic       mode_chg_q;

    function automatic logic hit(input logic [`PPD_ADDR_W-1:0] off);
        return reg_addr == off;
    endfunction

    wire       wr_mode  = reg_we & hit(`PPD_OFF_EXTCTL);
    wire [2:0] mode     = extctl_q[7:5];
    wire       sw_mode  = (mode == PPD_M_STD) | (mode == PPD_M_BIDIR);
    wire       m_pfifo  = mode == PPD_M_PFIFO;
    wire       m_efifo  = mode == PPD_M_EFIFO;
    wire       hw_mode  = m_pfifo | m_efifo;
    wire       dma_mode = hw_mode | (mode == PPD_M_TEST);
    // Direction forced forward where the mode is one-way
    wire       dir_bwd  = devctl_q[`PPD_DEVCTL_DIR] &
                          ((mode == PPD_M_BIDIR) | m_efifo);
    wire       demand   = setup_q[`PPD_SETUP_DEMAND];
    wire       dma_en   = extctl_q[`PPD_EXT_DMA_EN] &
                          ~extctl_q[`PPD_EXT_SERVICE] & dma_mode;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            data_q     <= 8'h00;
            devctl_q   <= `PPD_RST_DEVCTL;
            extctl_q   <= `PPD_RST_EXTCTL;
            fair_q     <= `PPD_RST_FAIRNESS;
            setup_q    <= `PPD_RST_SETUP;
            mode_chg_q <= 1'b0;
        end
        else
        begin
            mode_chg_q <= wr_mode & (reg_wdata[7:5] != mode);
            if (reg_we & hit(`PPD_OFF_DATA))
                data_q <= reg_wdata;
            if (reg_we & hit(`PPD_OFF_DEVCTL))
                devctl_q <= reg_wdata;
            if (wr_mode)
                extctl_q <= {reg_wdata[7:2], 2'h0};
            if (reg_we & hit(`PPD_OFF_FAIRNESS))
                fair_q <= {1'b0, reg_wdata[6:4], 1'b0, reg_wdata[2:0]};
            if (reg_we & hit(`PPD_OFF_SETUP))
                setup_q <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tagged FIFO, bit 8 set marks a command byte

    localparam int IDX_W = $clog2(DEPTH);

    logic [8:0]       mem_q [DEPTH];
    logic [IDX_W-1:0] wp_q;
    logic [IDX_W-1:0] rp_q;
    logic [CNT_W-1:0] cnt_q;
    logic             push;
    logic [8:0]       push_val;
    logic             pop;

    wire fifo_full  = cnt_q == CNT_W'(DEPTH);
    wire fifo_empty = cnt_q == '0;
    wire [CNT_W-1:0] fifo_free = CNT_W'(DEPTH) - cnt_q;
    wire [8:0] head = mem_q[rp_q];
    wire flush = sw_mode | mode_chg_q;

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_mem
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    mem_q[gi] <= 9'h000;
                else if (push & (wp_q == IDX_W'(gi)))
                    mem_q[gi] <= push_val;
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else if (flush)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= wp_q + IDX_W'(1);
            if (pop)
                rp_q <= rp_q + IDX_W'(1);
            cnt_q <= cnt_q + CNT_W'(push) - CNT_W'(pop);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Push and pop sources

    logic [6:0] rle_q;
    logic [7:0] rle_byte_q;
    logic       rle_run_q;
    ppd_fw_state_t fw_q;

    wire fifo_wr_port = reg_we & (hit(`PPD_OFF_ADDR_FIFO) & m_efifo |
                                  hit(`PPD_OFF_DATA_FIFO) & m_efifo |
                                  hit(`PPD_OFF_COMPAT_FIFO) & m_pfifo);
    wire sw_push  = fifo_wr_port & ~dir_bwd & ~fifo_full;
    wire dma_push = dma_xfer & dma_req & ~dir_bwd & ~fifo_full;
    // Backward captures while RUN_LENGTH_EXPANDER run is idle; a byte arriving mid-run is lost
    wire peri_cap = peri_stb & m_efifo & dir_bwd & ~rle_run_q;
    wire peri_cmd = ~busy;
    wire rle_cmd  = peri_cap & peri_cmd & ~pd_s2_q[7];
    wire peri_push = (peri_cap & ~rle_cmd | rle_run_q) & ~fifo_full;
    wire fw_pop   = (fw_q == PPD_FW_IDLE) & hw_mode & ~dir_bwd &
                    ~fifo_empty;
    wire dma_pop  = dma_xfer & dma_req & dir_bwd & ~fifo_empty;
    wire sw_pop   = reg_re & hit(`PPD_OFF_DATA_FIFO) & dir_bwd & ~fifo_empty;

    always_comb
    begin
        push     = ~flush & (dma_push | sw_push | peri_push);
        pop      = ~flush & (dma_pop | fw_pop | sw_pop);
        // DMA bytes always carry a data tag
        if (dma_push)
            push_val = {1'b0, dw_s2_q};
        else if (sw_push)
            push_val = {hit(`PPD_OFF_ADDR_FIFO), reg_wdata};
        else if (rle_run_q)
            push_val = {1'b0, rle_byte_q};
        else
            push_val = {peri_cmd, pd_s2_q};
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rle_q      <= 7'h00;
            rle_byte_q <= 8'h00;
            rle_run_q  <= 1'b0;
        end
        else if (flush)
        begin
            rle_q     <= 7'h00;
            rle_run_q <= 1'b0;
        end
        else if (rle_cmd)
            rle_q <= pd_s2_q[6:0];
        else if (peri_cap & ~peri_cmd & (rle_q != 7'h00))
        begin
            rle_byte_q <= pd_s2_q;
            rle_run_q  <= 1'b1;
        end
        else if (rle_run_q & ~fifo_full)
        begin
            rle_q <= rle_q - 7'h01;
            if (rle_q == 7'h01)
                rle_run_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Logic clock tick, flush time-out, fairness and request

    localparam int TDIV = `PPD_TICK_DIV;

    logic [3:0] tdiv_q;
    logic [7:0] flush_cnt_q;
    logic       flush_on_q;
    logic       flush_hit_q;
    logic [5:0] act_q;
    logic [7:0] inact_q;
    logic       hold_q;
    logic [2:0] burst_q;

    wire tick = tdiv_q == 4'(TDIV - 1);
    wire [5:0] act_lim = (fair_q[2:0] == 3'h0) ? `PPD_ACT_MIN :
                         `PPD_ACT_STEP * ({3'h0, fair_q[2:0]} + 6'd1);
    wire [7:0] inact_lim = `PPD_INACT_BASE +
                           `PPD_INACT_STEP * {5'h00, fair_q[6:4]};
    wire act_end  = dma_req & dma_xfer & (act_q + 6'd1 == act_lim);
    wire fair_ok  = ~hold_q;
    wire level_ok = dir_bwd ? (cnt_q >= `PPD_THRESHOLD)
                            : (fifo_free >= `PPD_THRESHOLD);
    wire can_serve = dir_bwd ? ~fifo_empty : ~fifo_full;
    wire burst_end = dma_xfer & (burst_q == `PPD_DEMAND_BURST - 3'd1);
    wire mech_rst  = mode_chg_q | ~dma_en;
    wire start_dem = demand & fair_ok & (level_ok | flush_hit_q);
    wire start_nd  = ~demand & fair_ok & can_serve;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            tdiv_q <= 4'h0;
        else
            tdiv_q <= tick ? 4'h0 : tdiv_q + 4'h1;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            flush_cnt_q <= 8'h00;
            flush_on_q  <= 1'b0;
            flush_hit_q <= 1'b0;
        end
        else if (mech_rst | dma_req | ~dir_bwd | ~demand)
        begin
            flush_cnt_q <= 8'h00;
            flush_on_q  <= 1'b0;
            flush_hit_q <= 1'b0;
        end
        else
        begin
            if (peri_push)
                flush_on_q <= 1'b1;
            if (flush_on_q & tick)
            begin
                flush_cnt_q <= flush_cnt_q + 8'h01;
                if (flush_cnt_q == `PPD_FLUSH_TERM)
                    flush_hit_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dma_req <= 1'b0;
            act_q   <= 6'h00;
            inact_q <= 8'h00;
            hold_q  <= 1'b0;
            burst_q <= 3'h0;
        end
        else if (mech_rst)
        begin
            dma_req <= 1'b0;
            act_q   <= 6'h00;
            inact_q <= 8'h00;
            hold_q  <= 1'b0;
            burst_q <= 3'h0;
        end
        else if (hold_q)
        begin
            if (tick)
                inact_q <= inact_q + 8'h01;
            if (tick & (inact_q + 8'h01 >= inact_lim))
                hold_q <= 1'b0;
        end
        else if (dma_req)
        begin
            if (dma_xfer)
            begin
                act_q   <= act_q + 6'd1;
                burst_q <= burst_end ? 3'h0 : burst_q + 3'h1;
            end
            if (act_end)
            begin
                dma_req <= 1'b0;
                hold_q  <= 1'b1;
                inact_q <= 8'h00;
                act_q   <= 6'h00;
                burst_q <= 3'h0;
            end
            else if (demand ? (burst_end & ~level_ok) | ~can_serve
                            : ~can_serve)
            begin
                dma_req <= 1'b0;
                act_q   <= 6'h00;
                burst_q <= 3'h0;
            end
        end
        else if (start_dem | start_nd)
            dma_req <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Forward writer

    logic [7:0] fw_data_q;
    logic       fw_tag_q;
    logic       fw_stb_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fw_q      <= PPD_FW_IDLE;
            fw_data_q <= 8'h00;
            fw_tag_q  <= 1'b0;
            fw_stb_q  <= 1'b0;
        end
        else if (~hw_mode | dir_bwd)
        begin
            fw_q     <= PPD_FW_IDLE;
            fw_stb_q <= 1'b0;
        end
        else
        begin
            case (fw_q)
                PPD_FW_IDLE:
                    if (fw_pop)
                    begin
                        fw_data_q <= head[7:0];
                        fw_tag_q  <= head[8];
                        fw_q      <= PPD_FW_SETUP;
                    end
                PPD_FW_SETUP:
                    if (~busy)
                    begin
                        fw_stb_q <= 1'b1;
                        fw_q     <= PPD_FW_STB;
                    end
                // 010 ends the strobe itself but still waits out busy: the
                // synchronised busy lags the pin, so a quick second strobe
                // would land on a busy peripheral. Hangs if busy never rises.
                PPD_FW_STB:
                begin
                    if (m_pfifo)
                        fw_stb_q <= 1'b0;
                    fw_q <= PPD_FW_WHI;
                end
                PPD_FW_WHI:
                    if (busy)
                    begin
                        fw_stb_q <= 1'b0;
                        fw_q     <= PPD_FW_WLO;
                    end
                PPD_FW_WLO:
                    if (~busy)
                        fw_q <= PPD_FW_IDLE;
                default:
                    fw_q <= PPD_FW_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins and read data

    logic [7:0] rd_mux;

    wire [7:0] cfg_a = 8'(setup_q[`PPD_SETUP_USER]) << `PPD_CFGA_USER;
    wire [7:0] cfg_b = {2'h0, setup_q[5:3], 1'b0, setup_q[1:0]};
    wire [7:0] ext_rd = {extctl_q[7:2], fifo_full, fifo_empty};
    wire [7:0] stat_rd = {~busy, 7'h00};
    // Software modes drive each line low while its device control bit is set
    wire pin_stb = hw_mode ? fw_stb_q : devctl_q[`PPD_DEVCTL_STB];
    wire pin_afd = m_efifo ? fw_tag_q
                           : devctl_q[`PPD_DEVCTL_AFD];

    always_comb
    begin
        rd_mux = 8'h00;
        case (reg_addr)
            `PPD_OFF_DATA:      rd_mux = data_q;
            `PPD_OFF_STATUS:    rd_mux = stat_rd;
            `PPD_OFF_DEVCTL:    rd_mux = devctl_q;
            `PPD_OFF_DATA_FIFO: rd_mux = head[7:0];
            `PPD_OFF_EXTCTL:    rd_mux = ext_rd;
            `PPD_OFF_FAIRNESS:  rd_mux = fair_q;
            `PPD_OFF_SETUP:     rd_mux = setup_q;
            `PPD_OFF_CFG_A:     rd_mux = cfg_a;
            `PPD_OFF_CFG_B:     rd_mux = cfg_b;
            default:            rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata          <= 8'h00;
            dma_rdata          <= 8'h00;
            port_data_lines_o  <= 8'h00;
            port_data_lines_oe <= 1'b0;
            strobe_line_n      <= 1'b1;
            autofeed_line_n    <= 1'b1;
        end
        else
        begin
            reg_rdata          <= reg_re ? rd_mux : 8'h00;
            dma_rdata          <= head[7:0];
            port_data_lines_o  <= hw_mode ? fw_data_q : data_q;
            port_data_lines_oe <= ~dir_bwd;
            strobe_line_n      <= ~pin_stb;
            autofeed_line_n    <= ~pin_afd;
        end
    end

endmodule // ppd_top

`default_nettype wire

// >>> verif/ppd_checker.sv
// Pin checks on ppd_top: read slot, strobe cycle, DMA fairness.
// Assumes one clock and the design's async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ppd_checker (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       reg_re,
    input wire logic [7:0] reg_rdata,
    input wire logic       dma_req,
    input wire logic       dma_ack_n,
    input wire logic [7:0] port_data_lines_o,
    input wire logic       port_data_lines_oe,
    input wire logic       strobe_line_n,
    input wire logic       autofeed_line_n,
    input wire logic       busy_line
);
    logic [5:0] acks_q;
    logic [7:0] gap_q;
    logic       fair_q;
    // Acks count at the pin, ahead of the design's synchroniser
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            acks_q <= 6'h00;
            gap_q  <= 8'h00;
            fair_q <= 1'h0;
        end
        else
        begin
            acks_q <= !dma_req ? 6'h00 : acks_q + 6'($fell(dma_ack_n));
            gap_q  <= dma_req ? 8'h00 : gap_q + 8'(gap_q != 8'hff);
            fair_q <= $fell(dma_req) ? (acks_q == 6'h01) : fair_q && !dma_req;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_rd_idle: assert property (!$past(reg_re) |-> reg_rdata == 8'h00)
        else $error("read data outside slot");
    chk_act_limit: assert property (acks_q <= 6'h20)
        else $error("request too long");
    chk_inact_min:
        assert property ($rose(dma_req) && fair_q |-> gap_q >= 8'h4d)
        else $error("request back too soon");
    chk_stb_data:
        assert property (!strobe_line_n && $past(!strobe_line_n)
            |-> $stable(port_data_lines_o)) else $error("data moved");
    chk_stb_afd:
        assert property (!strobe_line_n && $past(!strobe_line_n)
            |-> $stable(autofeed_line_n)) else $error("autofeed moved");
    chk_stb_setup:
        assert property ($fell(strobe_line_n) |-> $stable(port_data_lines_o))
        else $error("data late");
    chk_stb_busy: assert property ($fell(strobe_line_n) |-> !busy_line)
        else $error("strobe while busy");
    chk_oe_stb: assert property (!strobe_line_n |-> port_data_lines_oe)
        else $error("strobe undriven");
    cover property ($fell(strobe_line_n));
    cover property ($fell(dma_req) && acks_q == 6'h10);
    cover property ($rose(dma_req) && fair_q);
endmodule // ppd_checker
bind ppd_top ppd_checker i_chk (.clk(clk), .rstn(rstn), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .dma_req(dma_req), .dma_ack_n(dma_ack_n),
    .port_data_lines_o(port_data_lines_o), .busy_line(busy_line),
    .port_data_lines_oe(port_data_lines_oe), .strobe_line_n(strobe_line_n),
    .autofeed_line_n(autofeed_line_n));
`default_nettype wire

// >>> verif/ppd_peri_model.sv
// Peripheral model: captures each strobe and answers with busy.
// Assumes forward transfers only.
`timescale 1ns/1ps
`default_nettype none
module ppd_peri_model #(parameter int DLY = 5) (
    input  wire logic       clk,
    input  wire logic       strobe_line_n,
    input  wire logic       autofeed_line_n,
    input  wire logic [7:0] port_data_lines_o,
    output var logic        busy_line,
    output var logic [7:0]  rx_byte,
    output var logic        rx_afd,
    output var int          rx_cnt
);
    initial
    begin
        busy_line = 1'h0;
        rx_cnt = 0;
        forever
        begin
            @(negedge strobe_line_n);
            rx_byte = port_data_lines_o;
            rx_afd = autofeed_line_n;
            rx_cnt++;
            // Busy rises on the clock after the strobe falls so a second strobe must wait for it
            @(posedge clk);
            busy_line <= 1'h1;
            wait (strobe_line_n === 1'h1);
            repeat (DLY) @(posedge clk);
            busy_line <= 1'h0;
        end
    end
endmodule // ppd_peri_model
`default_nettype wire

// >>> verif/tb_ppd_top.sv
// Bench for ppd_top: registers, FIFO ports, peripheral cycles, demand DMA.
// Assumes the peripheral model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_ppd_top;
    localparam int DEPTH = 16;
    logic       clk;
    logic       rstn = 1'h0;
    logic       reg_we = 1'h0;
    logic       reg_re = 1'h0;
    logic       dma_ack_n = 1'h1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] dma_wdata = 8'h00;
    logic [7:0] reg_rdata, dma_rdata, pd_o, rx_byte, s, v;
    logic       dma_req, pd_oe, stb_n, afd_n, busy, rx_afd;
    logic [8:0] q[$];
    int         rx_cnt, n, k, nr = 0, cyc = 0, mismatches = 0, n_checks = 0;
    ppd_top #(.DEPTH(DEPTH), .CNT_W(5)) i_dut (.clk(clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .dma_req(dma_req),
        .dma_ack_n(dma_ack_n), .dma_wdata(dma_wdata), .dma_rdata(dma_rdata),
        .port_data_lines_i(8'h00), .port_data_lines_o(pd_o),
        .port_data_lines_oe(pd_oe), .strobe_line_n(stb_n),
        .autofeed_line_n(afd_n), .busy_line(busy), .peri_ack_n(1'h1));
    ppd_peri_model #(.DLY(5)) i_peri (.clk(clk), .strobe_line_n(stb_n),
        .autofeed_line_n(afd_n), .port_data_lines_o(pd_o), .busy_line(busy),
        .rx_byte(rx_byte), .rx_afd(rx_afd), .rx_cnt(rx_cnt));
    initial
    begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            test_done();
        end
    end
    task automatic test_done();
        if (mismatches == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, exp, m);
        n_checks++;
        if ((got & m) !== (exp & m))
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got & m, exp & m);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'h1;
        @(posedge clk);
        reg_we <= 1'h0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] e, m);
        @(posedge clk);
        reg_addr <= a;
        reg_re <= 1'h1;
        @(posedge clk);
        reg_re <= 1'h0;
        #1;
        chk(reg_rdata, e, m);
    endtask
    // Ack low and high four cycles each, so the synchroniser sees both
    task automatic xfer();
        dma_wdata <= 8'($urandom);
        dma_ack_n <= 1'h0;
        repeat (4) @(posedge clk);
        dma_ack_n <= 1'h1;
        repeat (4) @(posedge clk);
    endtask
    task automatic wait_req();
        for (k = 0; dma_req !== 1'h1 && k < 200; k++)
            @(posedge clk);
    endtask
    task automatic rx_next();
        for (k = 0; rx_cnt == nr && k < 300; k++)
            @(posedge clk);
        nr++;
        v = {7'h00, rx_afd};
        chk(rx_byte, q[0][7:0], 8'hff);
        chk(v, {7'h00, q[0][8]}, 8'hff);
        void'(q.pop_front());
    endtask
    initial
    begin
        void'($urandom(32'h5380));
        repeat (20) @(posedge clk);
        rstn <= 1'h1;
        rc(4'h7, 8'h07, 8'hff);
        rc(4'h8, 8'h00, 8'hff);
        rc(4'hf, 8'h00, 8'hff);
        s = 8'($urandom);
        wr(4'h8, s);
        rc(4'ha, s, 8'h3b);
        rc(4'h9, {4'h0, s[7], 3'h0}, 8'h08);
        wr(4'h5, 8'h5a);
        rc(4'h6, 8'h01, 8'h03);
        chk({7'h00, pd_oe}, 8'h01, 8'hff);
        wr(4'h2, 8'h02);
        wr(4'h6, 8'h40);
        for (n = 0; n < 5; n++)
        begin
            s = 8'($urandom);
            // Expected autofeed pin: low in 010 (control bit set), low for
            // the command byte and high for the data byte in 011
            q.push_back({n == 4, s});
            if (n == 3)
            begin
                repeat (3) rx_next();
                repeat (20) @(posedge clk);
                wr(4'h2, 8'h00);
                wr(4'h6, 8'h60);
            end
            wr(n < 3 ? 4'h5 : 4'(n), s);
        end
        repeat (2) rx_next();
        chk({7'h00, pd_oe}, 8'h01, 8'hff);
        wr(4'h8, 8'h40);
        wr(4'h6, 8'hc8);
        wait_req();
        for (n = 0; dma_req === 1'h1 && n < 40; n++)
        begin
            xfer();
            if (n == 0)
                v = dma_wdata;
        end
        chk(8'(n), 8'(DEPTH), 8'hff);
        chk(dma_rdata, v, 8'hff);
        rc(4'h6, 8'h02, 8'h03);
        chk(8'(rx_cnt), 8'h05, 8'hff);
        wr(4'h6, 8'h08);
        rc(4'h6, 8'h09, 8'h0b);
        chk({7'h00, dma_req}, 8'h00, 8'hff);
        wr(4'h7, 8'h00);
        wr(4'h6, 8'hc8);
        wait_req();
        xfer();
        chk({7'h00, dma_req}, 8'h00, 8'hff);
        for (k = 0; dma_req !== 1'h1 && k < 400; k++)
            @(posedge clk);
        chk(8'(k >= 70 && k < 120), 8'h01, 8'hff);
        test_done();
    end
endmodule // tb_ppd_top
`default_nettype wire
